// *** oewu_top.sv ***
// Overflow exception capture, wake and stop control with an APB register port
//
// How it works
// (RULE1) A signed 32-bit add, add-immediate or subtract that overflows raises an overflow exception.
// (RULE2) An overflow keeps the overflowing instruction's address as restart address.
// (RULE3) A fault on the first handler instruction after an overflow rewrites the restart address.
// (RULE4) Reset and non-maskable events share one fixed vector address.
// (RULE5) Enable and mask gate interrupts but never block wake from low power.
// (RULE6) Doze or halt enters low power, and doze stops the processor clock.
// (RULE7) Stop is high only with halt set, standby field stop and drive enable clear.
// (RULE8) With a crystal, wake starts a warm-up count and the clock is withheld until it ends; the code warms up only when the standby field is stop.
// (RULE9) A read-only revision register returns a fixed code.
// (RULE10) An overflow beats a coinciding later exception, whose address write is dropped.
// (RULE11) Delay-slot instructions are captured like any other on nested exceptions.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`default_nettype none
module oewu_top
   import oewu_pkg::*;
#(
   parameter logic [31:0] REV_ID = 32'h0000_1234, // Arbitrary identification value
   parameter int WARM_CYCLES = OEWU_WARM_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic arith_valid,
   input wire logic arith_sub,
   input wire logic arith_32bit,
   input wire logic [31:0] arith_a,
   input wire logic [31:0] arith_b,
   input wire logic [31:0] arith_pc,
   input wire logic exc_valid,
   input wire logic [31:0] exc_pc,
   input wire logic nmi_valid,
   input wire logic irq_req,
   input wire logic [2:0] irq_level,
   output logic exc_take,
   output logic [31:0] exc_vector,
   output logic irq_take,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic stop_out
);
   typedef struct packed {
      logic [31:0] ctrl;
      oewu_pwr_type pwr;
      logic [15:0] warm;
      logic [31:0] rdata;
      logic irq;
      logic stop;
      logic cpu_en;
      logic sys_en;
   } oewu_state_type;
   oewu_state_type s_q, s_d;

   logic [31:0] sum;
   logic ovf;
   logic [31:0] restart;
   logic ovf_cause;
   logic wake;
   logic irq_ok;
   logic wr_en;
   logic rd_en;
   logic [2:0] mask_lvl;
   logic [1:0] sby;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // Signed overflow: add operands of equal sign, or subtract operands of unequal sign, give a result of other sign than arith_a
   always_comb begin
      sum = arith_sub ? arith_a - arith_b : arith_a + arith_b;
      ovf = arith_valid && arith_32bit && // [RULE1]
            (arith_sub ? (arith_a[31] != arith_b[31]) && (sum[31] != arith_a[31])
                       : (arith_a[31] == arith_b[31]) && (sum[31] != arith_a[31]));
   end

   oewu_exc_capture u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .ovf_valid(ovf),
      .ovf_pc(arith_pc),
      .exc_valid(exc_valid),
      .exc_pc(exc_pc),
      .nmi_valid(nmi_valid),
      .take(exc_take),
      .vector(exc_vector),
      .restart_q(restart),
      .ovf_cause_q(ovf_cause)
   );

   assign mask_lvl = s_q.ctrl[OEWU_MASK_LSB +: 3];
   assign sby = s_q.ctrl[OEWU_SBY_LSB +: 2];
   // Any request wakes; only enabled requests at or above mask interrupt
   assign wake = irq_req; // [RULE5]
   assign irq_ok = irq_req && s_q.ctrl[OEWU_IE_BIT] && (irq_level >= mask_lvl); // [RULE5]
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   always_comb begin
      s_d = s_q;
      s_d.irq = irq_ok && (s_q.pwr == OEWU_RUN);
      if (wr_en && hit(paddr, OEWU_CTRL_OFF)) begin
         s_d.ctrl = pwdata;
      end
      if (rd_en) begin
         // Read data registered in setup so it is stable in the access phase
         if (hit(paddr, OEWU_CTRL_OFF)) begin
            s_d.rdata = s_q.ctrl;
         end else if (hit(paddr, OEWU_STAT_OFF)) begin
            s_d.rdata = {27'h0, ovf_cause, s_q.pwr == OEWU_WARM, s_q.pwr == OEWU_LOWPWR,
                         s_q.sys_en, s_q.cpu_en};
         end else if (hit(paddr, OEWU_ERA_OFF)) begin
            s_d.rdata = restart;
         end else if (hit(paddr, OEWU_REV_OFF)) begin
            s_d.rdata = REV_ID; // [RULE9]
         end else if (hit(paddr, OEWU_WARM_OFF)) begin
            s_d.rdata = {16'h0, s_q.warm};
         end else begin
            s_d.rdata = 32'h0;
         end
      end
      case (s_q.pwr)
         OEWU_RUN: begin
            if (s_q.ctrl[OEWU_DOZE_BIT] || s_q.ctrl[OEWU_HALT_BIT]) begin
               s_d.pwr = OEWU_LOWPWR; // [RULE6]
            end
         end
         OEWU_LOWPWR: begin
            if (wake) begin
               s_d.ctrl[OEWU_DOZE_BIT] = 1'b0;
               s_d.ctrl[OEWU_HALT_BIT] = 1'b0;
               if (s_q.ctrl[OEWU_XTAL_BIT] && sby == OEWU_SBY_STOP) begin
                  s_d.pwr = OEWU_WARM; // [RULE8]
                  s_d.warm = 16'(WARM_CYCLES);
               end else begin
                  s_d.pwr = OEWU_RUN;
               end
            end
         end
         OEWU_WARM: begin
            if (s_q.warm <= 16'h1) begin
               s_d.warm = 16'h0;
               s_d.pwr = OEWU_RUN; // [RULE8]
            end else begin
               s_d.warm = s_q.warm - 16'h1;
            end
         end
         default: s_d.pwr = OEWU_RUN;
      endcase
      // Halt alone in non-stop standby keeps the core clock running
      s_d.cpu_en = (s_d.pwr == OEWU_RUN) ||
                   (s_d.pwr == OEWU_LOWPWR && !s_d.ctrl[OEWU_DOZE_BIT] &&
                    sby != OEWU_SBY_STOP); // [RULE6]
      s_d.sys_en = s_d.pwr != OEWU_WARM; // [RULE8]
      s_d.stop = s_d.ctrl[OEWU_HALT_BIT] && s_d.ctrl[OEWU_SBY_LSB +: 2] == OEWU_SBY_STOP &&
                 !s_d.ctrl[OEWU_DRV_BIT]; // [RULE7]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{ctrl: OEWU_CTRL_RST, pwr: OEWU_RUN, warm: 16'h0, rdata: 32'h0,
                  irq: 1'b0, stop: 1'b0, cpu_en: 1'b1, sys_en: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq_take = s_q.irq;
   assign cpu_clk_en = s_q.cpu_en;
   assign sys_clk_en = s_q.sys_en;
   assign stop_out = s_q.stop;

   stop_cond_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
      stop_out |-> s_q.ctrl[OEWU_HALT_BIT] && sby == OEWU_SBY_STOP && !s_q.ctrl[OEWU_DRV_BIT])
      else $error("stop high without its condition");
   irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      irq_take |-> $past(s_q.ctrl[OEWU_IE_BIT]) && $past(irq_level) >= $past(mask_lvl))
      else $error("interrupt taken while gated");
   wake_gated_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
      s_q.pwr == OEWU_LOWPWR && irq_req && !s_q.ctrl[OEWU_IE_BIT] |=> s_q.pwr != OEWU_LOWPWR)
      else $error("masked request did not wake");
   doze_clock_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
      s_q.pwr == OEWU_RUN && s_q.ctrl[OEWU_DOZE_BIT] |=> !cpu_clk_en)
      else $error("doze did not stop the clock");
   warm_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
      s_q.pwr == OEWU_WARM |-> !sys_clk_en)
      else $error("clock given during warm-up");
   rev_const_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
      rd_en && hit(paddr, OEWU_REV_OFF) |=> prdata == REV_ID)
      else $error("revision read wrong");
   ovf_detect_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
      ovf && !nmi_valid |=> exc_take && ovf_cause)
      else $error("overflow not raised");
   ovf_prio_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
      ovf && exc_valid && !nmi_valid |=> exc_take && ovf_cause)
      else $error("later exception beat overflow");
endmodule
`default_nettype wire

// *** oewu_pkg.sv ***
// Package with constants and types for the overflow exception and wake unit
`default_nettype none
package oewu_pkg;
   localparam logic [7:0] OEWU_CTRL_OFF = 8'h00;
   localparam logic [7:0] OEWU_STAT_OFF = 8'h04;
   localparam logic [7:0] OEWU_ERA_OFF = 8'h08;
   localparam logic [7:0] OEWU_REV_OFF = 8'h0c;
   localparam logic [7:0] OEWU_WARM_OFF = 8'h10;
   // Control register fields
   localparam int OEWU_IE_BIT = 0;
   localparam int OEWU_DOZE_BIT = 1;
   localparam int OEWU_HALT_BIT = 2;
   localparam int OEWU_DRV_BIT = 3;
   localparam int OEWU_XTAL_BIT = 4;
   localparam int OEWU_SBY_LSB = 8;
   localparam int OEWU_MASK_LSB = 12;
   localparam logic [1:0] OEWU_SBY_STOP = 2'h1;
   localparam logic [31:0] OEWU_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OEWU_RESET_VECTOR = 32'hbfc0_0000;
   localparam logic [31:0] OEWU_GEN_VECTOR = 32'hbfc0_0180;
   // Warm-up time in microseconds and its cycle count at 40 MHz
   localparam int OEWU_WARM_US = 100;
   localparam int OEWU_CLK_MHZ = 40;
   localparam int OEWU_WARM_CYC = OEWU_WARM_US * OEWU_CLK_MHZ;
   localparam logic [15:0] OEWU_WARM_RST = 16'(OEWU_WARM_CYC);
   typedef enum logic [2:0] {
      OEWU_RUN = 3'b001,
      OEWU_LOWPWR = 3'b010,
      OEWU_WARM = 3'b100
   } oewu_pwr_type;
endpackage
`default_nettype wire

// *** oewu_exc_capture.sv ***
// Restart address capture and vector selection for pipeline exceptions
`default_nettype none
module oewu_exc_capture
   import oewu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ovf_valid,
   input wire logic [31:0] ovf_pc,
   input wire logic exc_valid,
   input wire logic [31:0] exc_pc,
   input wire logic nmi_valid,
   output logic take,
   output logic [31:0] vector,
   output logic [31:0] restart_q,
   output logic ovf_cause_q
);
   typedef struct packed {
      logic [31:0] era;
      logic ovf;
      logic [31:0] vec;
      logic take;
   } oewu_cap_type;
   oewu_cap_type s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.take = 1'b0;
      if (nmi_valid) begin
         s_d.vec = OEWU_RESET_VECTOR; // [RULE4]
         s_d.take = 1'b1;
      end else if (ovf_valid) begin
         // Older instruction wins; a coinciding later request is dropped [RULE10]
         s_d.era = ovf_pc; // [RULE2]
         s_d.ovf = 1'b1;
         s_d.vec = OEWU_GEN_VECTOR;
         s_d.take = 1'b1;
      end else if (exc_valid) begin
         // Handler fault after overflow rewrites the address, delay slot or not [RULE3] [RULE11]
         s_d.era = exc_pc;
         s_d.ovf = 1'b0;
         s_d.vec = OEWU_GEN_VECTOR;
         s_d.take = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{era: 32'h0, ovf: 1'b0, vec: OEWU_RESET_VECTOR, take: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign take = s_q.take;
   assign vector = s_q.vec;
   assign restart_q = s_q.era;
   assign ovf_cause_q = s_q.ovf;

   ovf_keeps_pc_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
      ovf_valid && !nmi_valid |=> restart_q == $past(ovf_pc))
      else $error("restart address not the overflowing instruction");
   nmi_vector_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
      nmi_valid |=> take && vector == OEWU_RESET_VECTOR)
      else $error("nmi not sent to reset vector");
   nested_update_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
      !ovf_valid && !nmi_valid && exc_valid |=> restart_q == $past(exc_pc) && !ovf_cause_q)
      else $error("nested fault did not update restart address");
endmodule
`default_nettype wire

// *** oewu_pipe_model.sv ***
// Pipeline and interrupt source model facing the unit
`default_nettype none
module oewu_pipe_model (
   input wire logic clk,
   output logic av,
   output logic sub,
   output logic b32,
   output logic [31:0] a,
   output logic [31:0] b,
   output logic [31:0] apc,
   output logic ev,
   output logic [31:0] xpc,
   output logic nv,
   output logic irq,
   output logic [2:0] lvl
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {av, sub, b32, a, b, apc, ev, xpc, nv, irq, lvl} = '0;
   // One issue slot; stale operands are inverted, never left showing
   task automatic step(input logic [2:0] k, input logic [31:0] x, y, p, q, input logic s, w);
      @(posedge clk);
      {av, ev, nv} <= k;
      {a, b, apc, xpc, sub, b32} <= {x, y, p, q, s, w};
      @(posedge clk);
      {av, ev, nv} <= 3'h0;
      {a, b, apc, xpc} <= {~x, ~y, ~p, ~q};
   endtask
   task automatic req(input logic r, input logic [2:0] l);
      @(posedge clk);
      {irq, lvl} <= {r, l};
   endtask
endmodule
`default_nettype wire

// *** overflow_exception_wake_unit_test.sv ***
// Self-checking bench for the overflow exception and wake unit
`default_nettype none
module overflow_exception_wake_unit_test
   import oewu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WARM = 8;
   localparam logic [31:0] REV = 32'h0000_5a3c; // Arbitrary value
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, arith_a, arith_b, arith_pc, exc_pc, exc_vector, rd, x, y;
   logic pready, pslverr, arith_valid, arith_sub, arith_32bit, exc_valid, nmi_valid, irq_req;
   logic exc_take, irq_take, cpu_clk_en, sys_clk_en, stop_out, s, e;
   logic [2:0] irq_level;
   int err_count = 0, n_tests = 0, cyc = 0, n;
   integer seed = 32'ha824;
   always #12.5 pclk = ~pclk;
   oewu_top #(.REV_ID(REV), .WARM_CYCLES(WARM)) i_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .arith_valid, .arith_sub,
      .arith_32bit, .arith_a, .arith_b, .arith_pc, .exc_valid, .exc_pc, .nmi_valid, .irq_req,
      .irq_level, .exc_take, .exc_vector, .irq_take, .cpu_clk_en, .sys_clk_en, .stop_out);
   oewu_pipe_model i_pipe (.clk(pclk), .av(arith_valid), .sub(arith_sub), .b32(arith_32bit),
      .a(arith_a), .b(arith_b), .apc(arith_pc), .ev(exc_valid), .xpc(exc_pc),
      .nv(nmi_valid), .irq(irq_req), .lvl(irq_level));
   task automatic complete_run;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   function automatic logic ovf(input logic [31:0] p, q, input logic sb);
      logic [31:0] r;
      r = sb ? p - q : p + q;
      return (sb ? p[31] != q[31] : p[31] == q[31]) && r[31] != p[31];
   endfunction
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         complete_run;
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("vector", exc_vector, OEWU_RESET_VECTOR);
      chk("stop", stop_out, 1'b0);
      apb(1'b1, OEWU_REV_OFF, 32'hffff_ffff);
      apb(1'b0, OEWU_REV_OFF, 32'h0);
      chk("revision", rd, REV);
      chk("slave error", pslverr, 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", rd, 32'h0);
      for (int i = 0; i < 16; i++) begin
         x = i ? $random(seed) : 32'h7fff_ffff;
         y = i ? $random(seed) : 32'h1;
         s = i ? 1'($random(seed)) : 1'b0;
         e = i % 4 != 3;
         i_pipe.step(3'b100, x, y, 32'h100 + 4 * i, 32'h0, s, e);
         #1;
         chk("overflow take", exc_take, ovf(x, y, s) && e);
         if (ovf(x, y, s) && e) begin
            chk("general vector", exc_vector, OEWU_GEN_VECTOR);
            apb(1'b0, OEWU_ERA_OFF, 32'h0);
            chk("restart", rd, 32'h100 + 4 * i);
         end
      end
      // The next instruction's request in the same cycle must lose
      i_pipe.step(3'b110, 32'h7fff_ffff, 32'h1, 32'h1000, 32'h1004, 1'b0, 1'b1);
      settle(1);
      chk("second take", exc_take, 1'b0);
      apb(1'b0, OEWU_ERA_OFF, 32'h0);
      chk("restart kept", rd, 32'h1000);
      i_pipe.step(3'b100, 32'h8000_0000, 32'h1, 32'h2000, 32'h0, 1'b1, 1'b1);
      i_pipe.step(3'b010, 32'h0, 32'h0, 32'h0, OEWU_GEN_VECTOR, 1'b0, 1'b1);
      apb(1'b0, OEWU_ERA_OFF, 32'h0);
      chk("nested restart", rd, OEWU_GEN_VECTOR);
      i_pipe.step(3'b101, 32'h7fff_ffff, 32'h1, 32'h3000, 32'h0, 1'b0, 1'b1);
      #1;
      chk("nmi vector", exc_vector, OEWU_RESET_VECTOR);
      // Halt with stop, drive enable set, then another standby mode
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OEWU_CTRL_OFF, 32'h4 | (i == 1 ? 32'h8 : 32'h0) | (i == 2 ? 32'h200 : 32'h100));
         settle(2);
         chk("stop", stop_out, i == 0);
         apb(1'b0, OEWU_STAT_OFF, 32'h0);
         chk("low power", rd[2], 1'b1);
         i_pipe.req(1'b1, 3'h7);
         settle(3);
         chk("masked take", irq_take, 1'b0);
         chk("stop after wake", stop_out, 1'b0);
         i_pipe.req(1'b0, 3'h0);
      end
      apb(1'b1, OEWU_CTRL_OFF, 32'h2);
      settle(3);
      chk("cpu clock", cpu_clk_en, 1'b0);
      i_pipe.req(1'b1, 3'h1);
      settle(3);
      chk("cpu clock wake", cpu_clk_en, 1'b1);
      i_pipe.req(1'b0, 3'h0);
      apb(1'b1, OEWU_CTRL_OFF, 32'h114);
      i_pipe.req(1'b1, 3'h2);
      n = 0;
      while (sys_clk_en !== 1'b0)
         settle(1);
      while (sys_clk_en !== 1'b1) begin
         settle(1);
         n++;
      end
      chk("warm cycles", n, WARM);
      i_pipe.req(1'b0, 3'h0);
      // Interrupts on, mask level three, random priorities
      apb(1'b1, OEWU_CTRL_OFF, 32'h3001);
      for (int i = 0; i < 6; i++) begin
         // First pass sits exactly on the mask level, which must still interrupt
         x = i ? {$random(seed)} % 8 : 32'h3;
         i_pipe.req(1'b1, x[2:0]);
         settle(3);
         chk("irq take", irq_take, x[2:0] >= 3'h3);
         i_pipe.req(1'b0, 3'h0);
         settle(2);
      end
      complete_run;
   end
endmodule
`default_nettype wire
